// [src/tbm_master.sv]
`timescale 1ns/1ps
// Overview of operation
// - After one setup the block runs a read, a write, a read then write, or a write then read.
// - It is the sole bus master and never arbitrates, detects lost arbitration or backs off.
// - It inserts no wait states and clocks the bus on its own schedule, ignoring any clock stretch.
// - The serial clock runs at 100 kHz, 400 kHz, about 769 kHz (800 kHz setting) or 1 MHz as selected.
// - A read fetches one to sixteen bytes from the slave into receive storage.
// - A write sends one to sixteen bytes from transmit storage to the slave.
// - A read then write reads up to sixteen bytes and then writes up to sixteen as one operation.
// - A write then read writes up to sixteen bytes and then reads up to sixteen as one operation.
// - Hardware sequences every phase of the transfer with no firmware action per bit or byte.
// - Both lines are open drain, only ever pulled low or released.
module tbm_master
  import tbm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start_i,
  input tbm_req_t req_i,
  input wire logic tx_we,
  input wire logic [3:0] tx_waddr,
  input wire logic [7:0] tx_wdata,
  input wire logic [3:0] rx_raddr,
  output logic [7:0] rx_rdata,
  output tbm_stat_t stat,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  input wire logic sda_i,
  output logic sda_oe
);
  tbm_state_t state_q;
  tbm_req_t req_q;
  tbm_stat_t stat_q;
  logic [6:0] qcnt_q;
  logic [1:0] qtr_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic held_q;
  logic is_addr_q;
  logic phase_q;
  logic [3:0] idx_q;
  logic ackbad_q;
  logic scl_low_q;
  logic sda_low_q;
  logic scl_low_d;
  logic sda_low_d;
  logic [7:0] rx_data_q;
  logic [7:0] tx_mem [TBM_BUF_DEPTH];
  logic [7:0] rx_mem [TBM_BUF_DEPTH];
  logic sda_sync;
  logic tick;
  logic qend;
  logic first_read;
  logic combined;
  logic cur_read;
  logic last_byte;
  logic m_acks;
  logic slave_nack;

  tbm_sync2 u_sda_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_i(sda_i),
    .sync_o(sda_sync)
  );

  // Sequence decode shared by the controller and the line drivers
  assign first_read = (req_q.mode == TBM_MODE_RD) || (req_q.mode == TBM_MODE_RD_WR);
  assign combined = (req_q.mode == TBM_MODE_RD_WR) || (req_q.mode == TBM_MODE_WR_RD);
  assign cur_read = phase_q ? ~first_read : first_read;
  assign last_byte = idx_q == (cur_read ? req_q.rd_len_m1 : req_q.wr_len_m1);
  assign m_acks = ~is_addr_q & cur_read;
  assign slave_nack = ~m_acks & ackbad_q;
  assign tick = stat_q.busy && (qcnt_q == 7'h00);
  assign qend = tick && (qtr_q == TBM_QTR_LAST);

  // Quarter-bit timer; no look at SCL, so a stretching slave is not waited for
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      qcnt_q <= 7'h00;
      qtr_q <= 2'h0;
    end else if (!stat_q.busy) begin
      qcnt_q <= 7'(tbm_qtr_len(req_i.speed) - 7'h01);
      qtr_q <= 2'h0;
    end else if (tick) begin
      qcnt_q <= 7'(tbm_qtr_len(req_q.speed) - 7'h01);
      qtr_q <= 2'(qtr_q + 2'h1);
    end else begin
      qcnt_q <= 7'(qcnt_q - 7'h01);
    end
  end

  // Main sequencer: one request runs every phase without help
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= TBM_IDLE;
      req_q <= TBM_REQ_RST;
      phase_q <= 1'b0;
      is_addr_q <= 1'b0;
      idx_q <= 4'h0;
      bit_q <= 3'h0;
    end else begin
      unique case (state_q)
        TBM_IDLE: begin
          if (start_i) begin
            req_q <= req_i;
            phase_q <= 1'b0;
            state_q <= TBM_START;
          end
        end
        TBM_START: begin
          if (qend) begin
            is_addr_q <= 1'b1;
            bit_q <= 3'h0;
            state_q <= TBM_BIT;
          end
        end
        TBM_BIT: begin
          if (qend) begin
            if (bit_q == TBM_BIT_LAST) begin
              state_q <= TBM_ACK;
            end else begin
              bit_q <= 3'(bit_q + 3'h1);
            end
          end
        end
        TBM_ACK: begin
          if (qend) begin
            bit_q <= 3'h0;
            if (slave_nack) begin
              state_q <= TBM_STOP;
            end else if (is_addr_q) begin
              is_addr_q <= 1'b0;
              idx_q <= 4'h0;
              state_q <= TBM_BIT;
            end else if (last_byte) begin
              if (combined && !phase_q) begin
                phase_q <= 1'b1;
                state_q <= TBM_START;
              end else begin
                state_q <= TBM_STOP;
              end
            end else begin
              idx_q <= 4'(idx_q + 4'h1);
              state_q <= TBM_BIT;
            end
          end
        end
        TBM_STOP: begin
          if (qend) begin
            state_q <= TBM_IDLE;
          end
        end
      endcase
    end
  end

  // Shift register; sampled bits of our own drive are harmless on writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shift_q <= TBM_BYTE_RST;
      held_q <= 1'b1;
    end else if (state_q == TBM_START && qend) begin
      shift_q <= {req_q.addr, cur_read};
    end else if (state_q == TBM_ACK && qend && is_addr_q) begin
      shift_q <= cur_read ? TBM_BYTE_RST : tx_mem[4'h0];
    end else if (state_q == TBM_ACK && qend) begin
      shift_q <= cur_read ? TBM_BYTE_RST : tx_mem[4'(idx_q + 4'h1)];
    end else if (state_q == TBM_BIT && tick && qtr_q == TBM_QTR_SAMPLE) begin
      shift_q <= {shift_q[6:0], sda_sync};
    end else if (state_q == TBM_BIT && tick && qtr_q == 2'h0) begin
      held_q <= shift_q[7];
    end
  end

  // Acknowledge sample; a mismatch on data bits is never treated as lost arbitration
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ackbad_q <= 1'b0;
    end else if (state_q == TBM_ACK && tick && qtr_q == TBM_QTR_SAMPLE) begin
      ackbad_q <= sda_sync;
    end
  end

  // Status: busy level, done pulse, nack held until next start
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stat_q <= TBM_STAT_RST;
    end else begin
      stat_q.done <= (state_q == TBM_STOP) && qend;
      if (state_q == TBM_IDLE && start_i) begin
        stat_q.busy <= 1'b1;
        stat_q.nack <= 1'b0;
      end else if (state_q == TBM_STOP && qend) begin
        stat_q.busy <= 1'b0;
      end
      if (state_q == TBM_ACK && qend && slave_nack) begin
        stat_q.nack <= 1'b1;
      end
    end
  end

  // Transmit storage, written by the user side at any time
  always_ff @(posedge sys_clk) begin
    if (tx_we) begin
      tx_mem[tx_waddr] <= tx_wdata;
    end
  end

  // Receive storage takes each complete read byte
  always_ff @(posedge sys_clk) begin
    if (state_q == TBM_BIT && qend && bit_q == TBM_BIT_LAST && m_acks) begin
      rx_mem[idx_q] <= shift_q;
    end
  end

  // Registered read port keeps the output on a flop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rx_data_q <= TBM_BYTE_RST;
    end else begin
      rx_data_q <= rx_mem[rx_raddr];
    end
  end

  // Line pattern per quarter; data bits and acks move only while SCL is low
  always_comb begin
    scl_low_d = 1'b0;
    sda_low_d = 1'b0;
    unique case (state_q)
      TBM_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
      end
      TBM_START: begin
        scl_low_d = (qtr_q == 2'h0) ? scl_low_q : (qtr_q == TBM_QTR_LAST);
        sda_low_d = qtr_q[1];
      end
      TBM_BIT: begin
        scl_low_d = (qtr_q == 2'h0) || (qtr_q == TBM_QTR_LAST);
        sda_low_d = ~m_acks & ~((qtr_q == 2'h0) ? shift_q[7] : held_q);
      end
      TBM_ACK: begin
        scl_low_d = (qtr_q == 2'h0) || (qtr_q == TBM_QTR_LAST);
        sda_low_d = m_acks & ~last_byte;
      end
      TBM_STOP: begin
        scl_low_d = (qtr_q == 2'h0);
        sda_low_d = ~qtr_q[1];
      end
    endcase
  end

  // Open-drain drive: the pad only ever pulls low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_low_q <= TBM_LINE_RST;
      sda_low_q <= TBM_LINE_RST;
    end else begin
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
  assign stat = stat_q;
  assign rx_rdata = rx_data_q;

  // Helper counters for the checks below
  logic [6:0] since_tick_q;
  logic [7:0] hi_q;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      since_tick_q <= 7'h00;
      hi_q <= 8'h00;
    end else begin
      since_tick_q <= (tick || !stat_q.busy) ? 7'h00 : 7'(since_tick_q + 7'h01);
      hi_q <= scl_low_q ? 8'h00 : 8'(hi_q + 8'h01);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Skip the take edge itself, where the new request is loaded
  a_mode_held: assert property (stat_q.busy && $past(stat_q.busy) |-> $stable(req_q.mode))
    else $error("mode changed mid transfer");
  a_no_arbitration: assert property (state_q == TBM_BIT && tick && qtr_q == TBM_QTR_SAMPLE && !m_acks
    && sda_sync != shift_q[7] |=> state_q == TBM_BIT && $stable(sda_low_q))
    else $error("transfer reacted to data mismatch");
  a_scl_no_wait: assert property (state_q == TBM_BIT && !scl_low_q |-> hi_q < {tbm_qtr_len(req_q.speed), 1'b0})
    else $error("clock high too long");
  a_qtr_rate: assert property (tick && state_q != TBM_IDLE && $past(stat_q.busy)
    |-> since_tick_q == 7'(tbm_qtr_len(req_q.speed) - 7'h01) || $past(state_q) == TBM_IDLE)
    else $error("quarter length wrong");
  a_read_bound: assert property (state_q == TBM_BIT && m_acks |-> idx_q <= req_q.rd_len_m1)
    else $error("read past requested length");
  a_write_bound: assert property (state_q == TBM_BIT && !is_addr_q && !cur_read
    |-> idx_q <= req_q.wr_len_m1)
    else $error("write past requested length");
  a_restart_only: assert property (state_q == TBM_ACK && qend && !slave_nack && !is_addr_q
    && last_byte && combined && !phase_q |=> state_q == TBM_START && phase_q)
    else $error("missing repeated start");
  a_start_busy: assert property (state_q == TBM_IDLE && start_i |=> stat_q.busy ##1 state_q == TBM_START)
    else $error("start not taken");
  a_done_pulse: assert property (stat_q.done |-> !stat_q.busy ##1 !stat_q.done)
    else $error("done not a clean pulse");
  a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("line driven high");
  a_start_cond: assert property ($rose(sda_low_q) && !scl_low_q |-> $past(state_q, 2) == TBM_START)
    else $error("data fell with clock high outside start");

  c_write_done: cover property (stat_q.done && req_q.mode == TBM_MODE_WR && !stat_q.nack);
  c_read_done: cover property (stat_q.done && req_q.mode == TBM_MODE_RD && !stat_q.nack);
  c_combined: cover property (state_q == TBM_START && phase_q && qend);
  c_nack: cover property (stat_q.done && stat_q.nack);
endmodule

// [src/tbm_pkg.sv]
package tbm_pkg;

  // System clock rate
  localparam int TBM_SYS_HZ = 40_000_000;

  // Serial clock rates offered
  localparam int TBM_RATE_100K_HZ = 100_000;
  localparam int TBM_RATE_400K_HZ = 400_000;
  localparam int TBM_RATE_800K_HZ = 800_000;
  localparam int TBM_RATE_1M_HZ = 1_000_000;

  // Each serial bit is four equal quarters; round up so no rate runs fast
  localparam int TBM_QTR_PER_BIT = 4;
  localparam logic [6:0] TBM_QTR_100K = 7'((TBM_SYS_HZ + TBM_QTR_PER_BIT * TBM_RATE_100K_HZ - 1)
                                           / (TBM_QTR_PER_BIT * TBM_RATE_100K_HZ));
  localparam logic [6:0] TBM_QTR_400K = 7'((TBM_SYS_HZ + TBM_QTR_PER_BIT * TBM_RATE_400K_HZ - 1)
                                           / (TBM_QTR_PER_BIT * TBM_RATE_400K_HZ));
  localparam logic [6:0] TBM_QTR_800K = 7'((TBM_SYS_HZ + TBM_QTR_PER_BIT * TBM_RATE_800K_HZ - 1)
                                           / (TBM_QTR_PER_BIT * TBM_RATE_800K_HZ));
  localparam logic [6:0] TBM_QTR_1M = 7'((TBM_SYS_HZ + TBM_QTR_PER_BIT * TBM_RATE_1M_HZ - 1)
                                         / (TBM_QTR_PER_BIT * TBM_RATE_1M_HZ));

  // Buffer depth, field positions and reset values
  localparam int TBM_BUF_DEPTH = 16;
  localparam logic [1:0] TBM_QTR_LAST = 2'h3;
  localparam logic [1:0] TBM_QTR_SAMPLE = 2'h2;
  localparam logic [2:0] TBM_BIT_LAST = 3'h7;
  localparam logic [7:0] TBM_BYTE_RST = 8'h00;
  localparam logic TBM_LINE_RST = 1'b0;

  typedef enum logic [1:0] {TBM_MODE_RD, TBM_MODE_WR, TBM_MODE_RD_WR, TBM_MODE_WR_RD} tbm_mode_t;
  typedef enum logic [1:0] {TBM_SPD_100K, TBM_SPD_400K, TBM_SPD_800K, TBM_SPD_1M} tbm_speed_t;
  typedef enum logic [2:0] {TBM_IDLE, TBM_START, TBM_BIT, TBM_ACK, TBM_STOP} tbm_state_t;

  // Transfer request; lengths are byte count minus one (1..16 bytes)
  typedef struct packed {
    tbm_mode_t mode;
    tbm_speed_t speed;
    logic [6:0] addr;
    logic [3:0] wr_len_m1;
    logic [3:0] rd_len_m1;
  } tbm_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic nack;
  } tbm_stat_t;

  localparam tbm_req_t TBM_REQ_RST = '0;
  localparam tbm_stat_t TBM_STAT_RST = '0;

  // Quarter-bit length in system clocks for a speed setting
  function automatic logic [6:0] tbm_qtr_len(input tbm_speed_t spd);
    unique case (spd)
      TBM_SPD_100K: tbm_qtr_len = TBM_QTR_100K;
      TBM_SPD_400K: tbm_qtr_len = TBM_QTR_400K;
      TBM_SPD_800K: tbm_qtr_len = TBM_QTR_800K;
      TBM_SPD_1M: tbm_qtr_len = TBM_QTR_1M;
    endcase
  endfunction

endpackage

// [src/tbm_sync2.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for a pin level
module tbm_sync2 (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic sync_q;

  // First stage feeds only the second; bus idles high
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// [verification/tbm_slave_model.sv]
`timescale 1ns/1ps
// Behavioural slave device on the far side of the two-wire bus
module tbm_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  logic [7:0] rmem [16];
  logic [7:0] wmem [16];
  logic [7:0] sh;
  logic [7:0] abyte;
  logic [3:0] bitc;
  logic [1:0] phase;
  logic rd;
  logic sel;
  logic mack;
  logic skip;
  int idx;
  int n_start;
  initial begin
    {sda_pull, phase, bitc, rd, sel, mack, skip, sh, abyte} = '0;
    idx = 0;
    n_start = 0;
  end
  // Start or repeated start: data falls while clock high
  always @(negedge sda) if (scl === 1'b1) begin
    phase = 2'h1;
    bitc = 4'h0;
    skip = 1'b1;
    sda_pull = 1'b0;
    idx = 0;
    n_start++;
  end
  // Stop: data rises while clock high
  always @(posedge sda) if (scl === 1'b1) begin
    phase = 2'h0;
    sda_pull = 1'b0;
  end
  // Sample on the rising clock
  always @(posedge scl) if (phase != 2'h0) begin
    if (bitc < 4'h8) sh = {sh[6:0], sda};
    else mack = sda;
  end
  // Drive only while clock low; never holds the clock, so no stretch
  always @(negedge scl) if (phase != 2'h0) begin
    if (skip) begin
      // Clock fall that closes the start carries no bit
      skip = 1'b0;
    end else if (bitc < 4'h7) begin
      bitc++;
      if (phase == 2'h2 && rd && sel) sda_pull = ~rmem[idx][4'h7 - bitc];
    end else if (bitc == 4'h7) begin
      bitc = 4'h8;
      if (phase == 2'h1) begin
        abyte = sh;
        rd = sh[0];
        sel = (sh[7:1] == ADDR);
      end
      if (phase == 2'h2 && !rd) begin
        wmem[idx[3:0]] = sh;
        idx++;
      end
      // Ack address and written bytes; release for the master's ack
      sda_pull = sel && !(phase == 2'h2 && rd);
    end else begin
      bitc = 4'h0;
      sda_pull = 1'b0;
      if (phase == 2'h1) begin
        phase = 2'h2;
        mack = 1'b0;
      end else if (rd) idx++;
      if (sel && rd && mack == 1'b0) sda_pull = ~rmem[idx][7];
    end
  end
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import tbm_pkg::*;
  logic sys_clk;
  logic reset;
  logic start_i;
  tbm_req_t req_i;
  logic tx_we;
  logic [3:0] tx_waddr;
  logic [7:0] tx_wdata;
  logic [3:0] rx_raddr;
  logic [7:0] rx_rdata;
  tbm_stat_t stat;
  logic scl_o;
  logic scl_oe;
  logic sda_o;
  logic sda_oe;
  logic sda_pull;
  logic jam;
  wire scl_w = ~scl_oe; // Pull-ups: a released line reads high
  // Jam pulls data low against the master to provoke a bit mismatch
  wire sda_w = ~(sda_oe | sda_pull | jam);
  int n_mismatch;
  int checks;
  int seed;
  logic [7:0] exp_tx [16];

  tbm_master u_tbm_master (.sys_clk(sys_clk), .reset(reset), .start_i(start_i), .req_i(req_i),
    .tx_we(tx_we), .tx_waddr(tx_waddr), .tx_wdata(tx_wdata), .rx_raddr(rx_raddr), .rx_rdata(rx_rdata),
    .stat(stat), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_i(sda_w), .sda_oe(sda_oe));
  tbm_slave_model u_slave (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  task print_verdict;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Quarter-bit length in clocks, rounded up so no rate runs fast
  function automatic int qtr(input tbm_speed_t s);
    int r;
    r = (s == TBM_SPD_100K) ? 100000 : (s == TBM_SPD_400K) ? 400000 : (s == TBM_SPD_800K) ? 800000 : 1000000;
    return (40000000 + 4 * r - 1) / (4 * r);
  endfunction

  task run(input tbm_mode_t m, input tbm_speed_t s, input logic [6:0] a, input logic [3:0] wl,
           input logic [3:0] rl);
    int k;
    int ns;
    realtime t0;
    logic ok;
    logic wr;
    logic rdp;
    wr = (m != TBM_MODE_RD);
    rdp = (m != TBM_MODE_WR);
    ok = (a == 7'h50);
    // Fill transmit storage and the slave's read data
    for (k = 0; k < 16; k++) begin
      exp_tx[k] = 8'($random(seed));
      u_slave.rmem[k] = 8'($random(seed));
      tx_we = 1'b1;
      tx_waddr = 4'(k);
      tx_wdata = exp_tx[k];
      @(negedge sys_clk);
    end
    tx_we = 1'b0;
    ns = u_slave.n_start;
    req_i = '{mode: m, speed: s, addr: a, wr_len_m1: wl, rd_len_m1: rl};
    start_i = 1'b1;
    @(negedge sys_clk);
    start_i = 1'b0;
    @(negedge sys_clk);
    chk(32'(stat.busy), 32'h1);
    // A request while busy must be ignored
    req_i.addr = ~a;
    start_i = 1'b1;
    @(negedge sys_clk);
    start_i = 1'b0;
    @(posedge scl_oe);
    @(negedge sys_clk);
    jam = !ok;
    @(posedge scl_oe);
    t0 = $realtime;
    @(negedge sys_clk);
    jam = 1'b0;
    @(posedge scl_oe);
    chk(32'(int'(($realtime - t0) / 25.0)), 32'(4 * qtr(s)));
    @(negedge sys_clk);
    k = 0;
    while (stat.done !== 1'b1 && k < 20000) begin
      @(negedge sys_clk);
      k++;
    end
    chk(32'(stat.done), 32'h1);
    chk(32'(stat.busy), 32'h0);
    chk(32'(stat.nack), 32'(!ok));
    chk({30'h0, scl_w, sda_w}, 32'h3);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    if (ok) begin
      chk(32'(u_slave.n_start - ns), (wr && rdp) ? 32'h2 : 32'h1);
      chk(32'(u_slave.abyte), {24'h0, a, m == TBM_MODE_RD || m == TBM_MODE_WR_RD});
      chk(32'(u_slave.idx), (m == TBM_MODE_WR || m == TBM_MODE_RD_WR) ? 32'(wl) + 1 : 32'(rl) + 1);
      if (wr) for (k = 0; k <= int'(wl); k++) chk(32'(u_slave.wmem[k]), 32'(exp_tx[k]));
      if (rdp) for (k = 0; k <= int'(rl); k++) begin
        rx_raddr = 4'(k);
        @(negedge sys_clk);
        @(negedge sys_clk);
        chk(32'(rx_rdata), 32'(u_slave.rmem[k]));
      end
    end
  endtask

  // Hang guard: the whole run needs about 52k clocks
  initial begin
    #2_000_000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {start_i, tx_we, tx_waddr, tx_wdata, rx_raddr, jam} = '0;
    req_i = TBM_REQ_RST;
    n_mismatch = 0;
    checks = 0;
    seed = 32'hB272;
    reset = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({28'h0, scl_oe, sda_oe, stat.busy, stat.nack}, 32'h0);
    reset = 1'b0;
    run(TBM_MODE_RD, TBM_SPD_1M, 7'h50, 4'h0, 4'hF);
    run(TBM_MODE_WR, TBM_SPD_800K, 7'h50, 4'hF, 4'h0);
    run(TBM_MODE_RD_WR, TBM_SPD_400K, 7'h50, 4'($random(seed)) & 4'h3, 4'($random(seed)) & 4'h3);
    run(TBM_MODE_WR_RD, TBM_SPD_100K, 7'h50, 4'h0, 4'h0);
    run(TBM_MODE_WR, TBM_SPD_1M, 7'h51, 4'h3, 4'h0);
    run(TBM_MODE_WR_RD, TBM_SPD_1M, 7'h50, 4'hF, 4'hF);
    print_verdict();
  end
endmodule
